/* File: irf_sequencer.sv */
// Purpose: image reading and formation sequencer with register port
// Assumes: switch and handshake pins asynchronous; samples on ref_clk
// Notes: all timing in ms from an internal tick
`timescale 1ns/1ps
`default_nettype none
module irf_sequencer #(
    parameter int MS_CYCLES = irf_pkg::MS_CYCLES,
    parameter int LINE_PIXELS = irf_pkg::LINE_PIXELS
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [irf_pkg::AW-1:0] addr,
    input wire logic [irf_pkg::DW-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [irf_pkg::DW-1:0] rd_data,
    output logic irq,
    input wire logic trailing_edge_switch,
    input wire logic shading_done,
    input wire logic feed_start,
    input wire logic sample_valid,
    input wire logic [irf_pkg::SW-1:0] sample,
    output logic exposure_lamp,
    output logic original_feed_clutch,
    output logic original_feed_motor,
    output logic shading_start,
    output logic read_sync,
    output logic form_sync,
    output logic jam,
    output logic service_call,
    output logic [irf_pkg::SW-1:0] upper_reference,
    output logic [irf_pkg::SW-1:0] lower_reference,
    output logic [irf_pkg::SW-1:0] offset_correction,
    output logic led_valid,
    output logic led_on,
    output logic line_end
);
    // A one-cycle millisecond still needs a one-bit tick counter
    localparam int TW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;
    localparam int PW = $clog2(LINE_PIXELS);
    localparam logic [TW-1:0] TICK_LAST = TW'(MS_CYCLES - 1);
    localparam logic [PW-1:0] PIX_LAST = PW'(LINE_PIXELS - 1);

    logic te;
    logic shade_ok;
    logic feed_go;
    logic [TW-1:0] tick_cnt;
    logic ms_tick;
    irf_pkg::irf_state_t state;
    irf_pkg::irf_state_t next_state;
    logic [irf_pkg::MSW-1:0] ms_cnt;
    irf_pkg::irf_act_t act;
    irf_pkg::irf_act_t next_act;
    logic [2:0] fail_cnt;
    logic enable;
    logic [irf_pkg::SW-1:0] white_max;
    logic [irf_pkg::SW-1:0] black_min;
    logic [7:0] thresh;
    logic [irf_pkg::IRQ_W-1:0] irq_stat;
    logic [irf_pkg::IRQ_W-1:0] irq_mask;
    logic [irf_pkg::IRQ_W-1:0] irq_evt;
    logic [irf_pkg::DW-1:0] line_cnt;
    logic [PW-1:0] pix_cnt;
    logic gray_valid;
    logic [7:0] gray;
    logic shade_timeout;
    logic shade_pass;
    logic line_done;
    logic fail_clr;

    // ==========================================
    // Pin synchronisers
    // ==========================================
    irf_sync2 u_sync_te (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin(trailing_edge_switch),
        .level(te)
    );
    irf_sync2 u_sync_shade (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin(shading_done),
        .level(shade_ok)
    );
    irf_sync2 u_sync_feed (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin(feed_start),
        .level(feed_go)
    );

    // ==========================================
    // Millisecond tick
    // ==========================================
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            tick_cnt <= '0;
            ms_tick <= 1'b0;
        end
        else
        begin
            ms_tick <= (tick_cnt == TICK_LAST);
            tick_cnt <= (tick_cnt == TICK_LAST) ? '0 : tick_cnt + 1'b1;
        end
    end

    // ==========================================
    // Sequence control
    // ==========================================
    assign shade_timeout = (state == irf_pkg::ST_SHADE) && !shade_ok && (ms_cnt >= irf_pkg::T_SHADE_LIMIT_MS);
    assign shade_pass = (state == irf_pkg::ST_SHADE) && shade_ok && !shade_timeout;

    always_comb
    begin
        next_state = state;
        next_act = act;
        case (state)
            irf_pkg::ST_IDLE:
            begin
                next_act = '0;
                if (enable && te)
                    next_state = irf_pkg::ST_SETTLE;
            end
            irf_pkg::ST_SETTLE:
            begin
                // lamp and shading after 1 s
                if (!te)
                    next_state = irf_pkg::ST_IDLE;
                else if (ms_cnt >= irf_pkg::T_SHADE_DELAY_MS)
                begin
                    next_state = irf_pkg::ST_SHADE;
                    next_act.lamp = 1'b1;
                    next_act.shade_start = 1'b1;
                end
            end
            irf_pkg::ST_SHADE:
            begin
                if (shade_timeout)
                begin
                    next_state = irf_pkg::ST_JAM;
                    next_act = '0;
                end
                else if (shade_ok)
                begin
                    next_state = irf_pkg::ST_READY;
                    next_act.shade_start = 1'b0;
                end
            end
            irf_pkg::ST_READY:
            begin
                // clutch and motor start at once; exposure lamp is already on, reading waits for the syncs
                if (feed_go)
                begin
                    next_state = irf_pkg::ST_FEED;
                    next_act.clutch = 1'b1;
                    next_act.motor = 1'b1;
                end
            end
            irf_pkg::ST_FEED:
            begin
                // syncs 450 ms after clutch on
                if (ms_cnt >= irf_pkg::T_SYNC_ON_MS)
                begin
                    next_state = irf_pkg::ST_EXPOSE;
                    next_act.read_sync = 1'b1;
                    next_act.form_sync = 1'b1;
                end
            end
            irf_pkg::ST_EXPOSE:
            begin
                if (!te)
                    next_state = irf_pkg::ST_TAIL;
            end
            irf_pkg::ST_TAIL:
            begin
                // syncs off 450 ms after switch opens
                if (ms_cnt >= irf_pkg::T_SYNC_OFF_MS)
                begin
                    next_act.read_sync = 1'b0;
                    next_act.form_sync = 1'b0;
                end
                if (ms_cnt >= irf_pkg::T_STOP_MS)
                begin
                    next_state = irf_pkg::ST_IDLE;
                    next_act = '0;
                end
            end
            irf_pkg::ST_JAM:
            begin
                // Wait for the original to be pulled before retry
                next_act = '0;
                if (!te)
                    next_state = irf_pkg::ST_IDLE;
            end
            default:
            begin
                next_state = irf_pkg::ST_IDLE;
                next_act = '0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= irf_pkg::ST_IDLE;
            act <= '0;
        end
        else
        begin
            state <= next_state;
            act <= next_act;
        end
    end

    // Elapsed ms since entering the current state
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            ms_cnt <= '0;
        else if (next_state != state)
            ms_cnt <= '0;
        else if (ms_tick && ms_cnt != '1)
            ms_cnt <= ms_cnt + 1'b1;
    end

    // ==========================================
    // Shading supervision
    // ==========================================
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            fail_cnt <= '0;
            jam <= 1'b0;
            service_call <= 1'b0;
        end
        else
        begin
            if (shade_timeout)
                jam <= 1'b1;
            else if (act.shade_start == 1'b0 && next_act.shade_start)
                jam <= 1'b0;
            if (shade_timeout)
            begin
                if (fail_cnt < irf_pkg::FAIL_LIMIT)
                    fail_cnt <= fail_cnt + 1'b1;
                if (fail_cnt + 1'b1 >= irf_pkg::FAIL_LIMIT)
                    service_call <= 1'b1;
            end
            else if (shade_pass)
                fail_cnt <= '0;
            else if (fail_clr)
            begin
                fail_cnt <= '0;
                service_call <= 1'b0;
            end
        end
    end

    // ==========================================
    // AGC and printhead data
    // ==========================================
    // gain set by white max and black min
    irf_agc_quant #(
        .SWID(irf_pkg::SW)
    ) u_agc (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(sample_valid && act.read_sync),
        .sample(sample),
        .white_max(white_max),
        .black_min(black_min),
        .out_valid(gray_valid),
        .gray(gray)
    );

    assign line_done = gray_valid && act.form_sync && (pix_cnt == PIX_LAST);

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            led_valid <= 1'b0;
            led_on <= 1'b0;
            line_end <= 1'b0;
            pix_cnt <= '0;
            line_cnt <= '0;
        end
        else
        begin
            led_valid <= gray_valid && act.form_sync;
            led_on <= gray_valid && act.form_sync && (gray < thresh);
            line_end <= line_done;
            if (!act.form_sync)
                pix_cnt <= '0;
            else if (gray_valid)
                pix_cnt <= line_done ? '0 : pix_cnt + 1'b1;
            if (line_done)
                line_cnt <= line_cnt + 1'b1;
            else if (state == irf_pkg::ST_FEED && ms_cnt == '0)
                line_cnt <= '0;
        end
    end

    // ==========================================
    // Register port
    // ==========================================
    assign fail_clr = wr_en && addr == irf_pkg::REG_CTRL && wr_data[irf_pkg::CTRL_FAIL_CLR];
    assign irq_evt = {line_done, shade_pass, shade_timeout && fail_cnt + 1'b1 >= irf_pkg::FAIL_LIMIT, shade_timeout};

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            enable <= 1'b0;
            white_max <= irf_pkg::WHITE_RST;
            black_min <= irf_pkg::BLACK_RST;
            thresh <= irf_pkg::THRESH_RST;
            irq_mask <= '0;
        end
        else if (wr_en)
        begin
            case (addr)
                irf_pkg::REG_CTRL: enable <= wr_data[irf_pkg::CTRL_ENABLE];
                irf_pkg::REG_IRQ_MASK: irq_mask <= wr_data[irf_pkg::IRQ_W-1:0];
                irf_pkg::REG_WHITE: white_max <= wr_data[irf_pkg::SW-1:0];
                irf_pkg::REG_BLACK: black_min <= wr_data[irf_pkg::SW-1:0];
                irf_pkg::REG_THRESH: thresh <= wr_data[7:0];
                default: ;
            endcase
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            irq_stat <= '0;
        else if (wr_en && addr == irf_pkg::REG_IRQ_STAT)
            irq_stat <= (irq_stat & ~wr_data[irf_pkg::IRQ_W-1:0]) | irq_evt;
        else
            irq_stat <= irq_stat | irq_evt;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rd_data <= '0;
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(irq_stat & irq_mask);
            rd_data <= '0;
            if (rd_en)
            begin
                case (addr)
                    irf_pkg::REG_CTRL: rd_data <= irf_pkg::DW'(enable);
                    irf_pkg::REG_STATUS: rd_data <= irf_pkg::DW'({service_call, jam, fail_cnt, act, state});
                    irf_pkg::REG_IRQ_STAT: rd_data <= irf_pkg::DW'(irq_stat);
                    irf_pkg::REG_IRQ_MASK: rd_data <= irf_pkg::DW'(irq_mask);
                    irf_pkg::REG_WHITE: rd_data <= irf_pkg::DW'(white_max);
                    irf_pkg::REG_BLACK: rd_data <= irf_pkg::DW'(black_min);
                    irf_pkg::REG_THRESH: rd_data <= irf_pkg::DW'(thresh);
                    irf_pkg::REG_LINES: rd_data <= line_cnt;
                    default: rd_data <= '0;
                endcase
            end
        end
    end

    // ==========================================
    // Output stage
    // ==========================================
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            upper_reference <= irf_pkg::WHITE_RST;
            lower_reference <= irf_pkg::BLACK_RST;
            offset_correction <= '0;
        end
        else
        begin
            upper_reference <= white_max;
            lower_reference <= black_min;
            offset_correction <= '0;
        end
    end

    assign exposure_lamp = act.lamp;
    assign original_feed_clutch = act.clutch;
    assign original_feed_motor = act.motor;
    assign shading_start = act.shade_start;
    assign read_sync = act.read_sync;
    assign form_sync = act.form_sync;
endmodule
`default_nettype wire

/* File: irf_pkg.sv */
// Purpose: shared constants and types for the image read/form sequencer
// Assumes: 200 MHz ref_clk, millisecond sequencing
// Notes: register map is word indexed on a 4-bit address
package irf_pkg;
    // ==========================================
    // Timing
    // ==========================================
    localparam int CLK_FREQ_HZ = 200_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES = CLK_FREQ_HZ / MS_PER_S;
    localparam int MSW = 16;
    localparam logic [MSW-1:0] T_SHADE_DELAY_MS = 16'd1000;
    localparam logic [MSW-1:0] T_SHADE_LIMIT_MS = 16'd30000;
    localparam logic [MSW-1:0] T_SYNC_ON_MS = 16'd450;
    localparam logic [MSW-1:0] T_SYNC_OFF_MS = 16'd450;
    localparam logic [MSW-1:0] T_STOP_MS = 16'd1325;
    localparam logic [2:0] FAIL_LIMIT = 3'd6;
    localparam int LINE_PIXELS = 14592;
    localparam int GRAY_LEVELS = 256;

    // ==========================================
    // Register map
    // ==========================================
    localparam int AW = 4;
    localparam int DW = 16;
    localparam logic [AW-1:0] REG_CTRL = 4'h0;
    localparam logic [AW-1:0] REG_STATUS = 4'h1;
    localparam logic [AW-1:0] REG_IRQ_STAT = 4'h2;
    localparam logic [AW-1:0] REG_IRQ_MASK = 4'h3;
    localparam logic [AW-1:0] REG_WHITE = 4'h4;
    localparam logic [AW-1:0] REG_BLACK = 4'h5;
    localparam logic [AW-1:0] REG_THRESH = 4'h6;
    localparam logic [AW-1:0] REG_LINES = 4'h7;
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_FAIL_CLR = 1;
    localparam int IRQ_W = 4;
    localparam int IRQ_JAM = 0;
    localparam int IRQ_SERVICE = 1;
    localparam int IRQ_SHADE_OK = 2;
    localparam int IRQ_LINE = 3;
    localparam int SW = 10;
    localparam logic [SW-1:0] WHITE_RST = 10'h3FF;
    localparam logic [SW-1:0] BLACK_RST = 10'h000;
    localparam logic [7:0] THRESH_RST = 8'h80;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETTLE = 3'b001,
        ST_SHADE = 3'b010,
        ST_READY = 3'b011,
        ST_FEED = 3'b100,
        ST_EXPOSE = 3'b101,
        ST_TAIL = 3'b110,
        ST_JAM = 3'b111
    } irf_state_t;

    typedef struct packed {
        logic lamp;
        logic clutch;
        logic motor;
        logic shade_start;
        logic read_sync;
        logic form_sync;
    } irf_act_t;
endpackage

/* File: irf_sync2.sv */
// Purpose: two-flop synchroniser for one pin level
// Assumes: input asynchronous to ref_clk
// Notes: first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module irf_sync2 (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pin,
    output logic level
);
    logic meta;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            meta <= 1'b0;
            level <= 1'b0;
        end
        else
        begin
            meta <= pin;
            level <= meta;
        end
    end
endmodule
`default_nettype wire

/* File: irf_agc_quant.sv */
// Purpose: gain-corrected quantiser of sensor samples to gray levels
// Assumes: white above black; samples from ADC logic on ref_clk
// Notes: one cycle latency, result clamps at both ends
`timescale 1ns/1ps
`default_nettype none
module irf_agc_quant #(
    parameter int SWID = irf_pkg::SW
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [SWID-1:0] sample,
    input wire logic [SWID-1:0] white_max,
    input wire logic [SWID-1:0] black_min,
    output logic out_valid,
    output logic [7:0] gray
);
    localparam logic [7:0] TOP = 8'(irf_pkg::GRAY_LEVELS - 1);
    logic [SWID+7:0] num;
    logic [SWID+7:0] den;
    logic [SWID+7:0] quo;

    // Span between references maps to full range, zero offset
    always_comb
    begin
        num = (SWID+8)'(sample - black_min) * (SWID+8)'(TOP);
        den = (SWID+8)'(white_max - black_min);
        quo = (den == '0) ? (SWID+8)'(TOP) : num / den;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            out_valid <= 1'b0;
            gray <= 8'h00;
        end
        else
        begin
            out_valid <= in_valid;
            if (sample <= black_min)
                gray <= 8'h00;
            else if (sample >= white_max)
                gray <= TOP;
            else
                gray <= quo[7:0];
        end
    end
endmodule
`default_nettype wire

/* File: irf_sequencer_assertions.sv */
// Purpose: port checker for the image read/form sequencer
// Assumes: MS_CYCLES matches the bound instance
// Notes: windows allow pin sync latency and ms tick skew
`timescale 1ns/1ps
`default_nettype none
module irf_sequencer_checker #(
    parameter int MS_CYCLES = 1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [irf_pkg::AW-1:0] addr,
    input wire logic [irf_pkg::DW-1:0] wr_data,
    input wire logic trailing_edge_switch,
    input wire logic exposure_lamp,
    input wire logic original_feed_clutch,
    input wire logic original_feed_motor,
    input wire logic shading_start,
    input wire logic read_sync,
    input wire logic form_sync,
    input wire logic jam,
    input wire logic [irf_pkg::SW-1:0] upper_reference,
    input wire logic [irf_pkg::SW-1:0] offset_correction,
    input wire logic led_valid,
    input wire logic line_end
);
    // ==========
    // Cycles since each event
    // ==========
    int hi;
    int lo;
    int cu;
    int sh;
    logic [irf_pkg::SW-1:0] wd;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            hi <= 0;
            lo <= 0;
            cu <= 0;
            sh <= 0;
            wd <= '0;
        end
        else
        begin
            hi <= $rose(trailing_edge_switch) ? 1 : hi + 1;
            lo <= $fell(trailing_edge_switch) ? 1 : lo + 1;
            cu <= $rose(original_feed_clutch) ? 1 : cu + 1;
            sh <= $rose(shading_start) ? 1 : sh + 1;
            wd <= wr_data[irf_pkg::SW-1:0];
        end
    end
    // Slack covers two-flop pin sync and tick phase
    function automatic logic win(int n, int t);
        return n >= t * MS_CYCLES && n <= (t + 1) * MS_CYCLES + 6;
    endfunction
    // ==========
    // Properties
    // ==========
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence s_white_wr;
        wr_en && addr == irf_pkg::REG_WHITE;
    endsequence
    property p_lamp_on;
        $rose(shading_start) |-> exposure_lamp && win(hi, 1000);
    endproperty
    property p_feed;
        $rose(original_feed_clutch) |-> exposure_lamp && original_feed_motor;
    endproperty
    property p_sync_on;
        $rose(read_sync) |-> form_sync && original_feed_clutch && win(cu, 450);
    endproperty
    property p_sync_off;
        $fell(read_sync) |-> !form_sync && win(lo, 450);
    endproperty
    property p_stop;
        $fell(original_feed_motor) |-> !original_feed_clutch && !exposure_lamp && win(lo, 1325);
    endproperty
    property p_jam;
        $rose(jam) |-> win(sh, 30000) ##1 !exposure_lamp && !shading_start;
    endproperty
    property p_ref;
        s_white_wr |=> ##1 upper_reference == $past(wd) && offset_correction == '0;
    endproperty
    property p_line;
        line_end |-> led_valid;
    endproperty
    a_lamp_on: assert property (p_lamp_on)
        else $error("lamp or shading start mistimed");
    a_feed: assert property (p_feed)
        else $error("clutch engaged without lamp and motor");
    a_sync_on: assert property (p_sync_on)
        else $error("sync rise mistimed");
    a_sync_off: assert property (p_sync_off)
        else $error("sync fall mistimed");
    a_stop: assert property (p_stop)
        else $error("feed stop mistimed or split");
    a_jam: assert property (p_jam)
        else $error("jam mistimed or actuators left on");
    a_ref: assert property (p_ref)
        else $error("reference level not applied");
    a_line: assert property (p_line)
        else $error("line end without pixel");
endmodule
`default_nettype wire

/* File: irf_copier_model.sv */
// Purpose: switches, sensor and feed handshake of the copier
// Assumes: bench commands original position and feed start
// Notes: hang keeps shading from finishing
`timescale 1ns/1ps
`default_nettype none
module irf_copier_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic shading_start,
    input wire logic read_sync,
    input wire logic te_cmd,
    input wire logic hang,
    input wire logic feed_req,
    output logic trailing_edge_switch,
    output logic shading_done,
    output logic feed_start,
    output logic sample_valid,
    output logic [irf_pkg::SW-1:0] sample
);
    logic [7:0] dly;
    logic [1:0] k;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            trailing_edge_switch <= 1'b0;
            feed_start <= 1'b0;
            shading_done <= 1'b0;
            sample_valid <= 1'b0;
            sample <= '0;
            dly <= 8'h00;
            k <= 2'h0;
        end
        else
        begin
            trailing_edge_switch <= te_cmd;
            feed_start <= feed_req;
            dly <= shading_start ? dly + 8'h01 : 8'h00;
            shading_done <= shading_start && !hang && dly > 8'h20;
            sample_valid <= read_sync && !sample_valid;
            // Idle data inverts so a stale value never looks valid
            if (read_sync && !sample_valid)
            begin
                k <= k + 2'h1;
                case (k)
                    2'h0: sample <= 10'h0C0;
                    2'h1: sample <= 10'h201;
                    2'h2: sample <= 10'h202;
                    default: sample <= 10'h3FF;
                endcase
            end
            else
                sample <= ~sample;
        end
    end
endmodule
`default_nettype wire

/* File: test_image_read_form_sequencer.sv */
// Purpose: register and sequence test of the sequencer
// Assumes: 1 ms shortened to one cycle, 8 pixel lines
// Notes: black 0x100, white 0x300 puts gray 128 at 0x202
`timescale 1ns/1ps
`default_nettype none
module test_image_read_form_sequencer;
    localparam int MS = 1;
    localparam int LP = 8;
    logic ref_clk, rst, wr_en, rd_en, irq, jam, service_call;
    logic [3:0] addr;
    logic [15:0] wr_data, rd_data, d;
    logic trailing_edge_switch, shading_done, feed_start, sample_valid;
    logic [9:0] sample, upper_reference, lower_reference, offset_correction;
    logic exposure_lamp, original_feed_clutch, original_feed_motor, shading_start;
    logic read_sync, form_sync, led_valid, led_on, line_end, te_cmd, hang, feed_req;
    logic [4:0] obs;
    int errors, total_checks, pix;
    assign obs = {original_feed_motor, read_sync, shading_done, exposure_lamp, jam};
    irf_sequencer #(.MS_CYCLES(MS), .LINE_PIXELS(LP)) u_dut (.*);
    irf_copier_model u_model (.*);
    // ==========
    // Bench tasks
    // ==========
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        v = rd_data;
    endtask
    task automatic rc(input logic [3:0] a, input logic [15:0] exp);
        rd(a, d);
        check(d, exp);
    endtask
    task automatic wait_obs(input int b, input logic v);
        int n;
        n = 0;
        while (obs[b] !== v && n < 40000)
        begin
            @(negedge ref_clk);
            n++;
        end
        check(n < 40000, 1'b1);
    endtask
    task automatic results;
        if (errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Pixels 0,1 of each group of four are lit, 2,3 dark
    always @(negedge ref_clk)
        if (led_valid === 1'b1)
        begin
            check(led_on, pix[1] == 1'b0);
            check(line_end, pix[2:0] == 3'h7);
            pix++;
        end
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // Run needs about 170 us
    initial
    begin
        #400000;
        errors++;
        results;
    end
    // ==========
    // Tests
    // ==========
    initial
    begin
        rst = 1'b1;
        addr = 4'h0;
        wr_data = 16'h0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        te_cmd = 1'b0;
        hang = 1'b1;
        feed_req = 1'b0;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        rc(irf_pkg::REG_WHITE, 16'h03FF);
        rc(irf_pkg::REG_BLACK, 16'h0000);
        rc(irf_pkg::REG_THRESH, 16'h0080);
        rc(irf_pkg::REG_STATUS, 16'h0000);
        wr(4'h9, 16'hFFFF);
        rc(4'h9, 16'h0000);
        wr(irf_pkg::REG_WHITE, 16'h0300);
        wr(irf_pkg::REG_BLACK, 16'h0100);
        wr(irf_pkg::REG_IRQ_MASK, 16'h0001);
        wr(irf_pkg::REG_CTRL, 16'h0001);
        check(upper_reference, 16'h0300);
        check(lower_reference, 16'h0100);
        te_cmd <= 1'b1;
        wait_obs(0, 1'b1);
        rd(irf_pkg::REG_STATUS, d);
        check(irq, 1'b1);
        check(d[11:9], 16'h0001);
        check(service_call, 1'b0);
        check(exposure_lamp, 1'b0);
        wr(irf_pkg::REG_IRQ_STAT, 16'h0001);
        rc(irf_pkg::REG_IRQ_STAT, 16'h0000);
        check(irq, 1'b0);
        te_cmd <= 1'b0;
        hang <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rc(irf_pkg::REG_STATUS, 16'h1200);
        te_cmd <= 1'b1;
        wait_obs(2, 1'b1);
        wait_obs(2, 1'b0);
        rd(irf_pkg::REG_STATUS, d);
        check(d[11:9], 16'h0000);
        check(d[2:0], irf_pkg::ST_READY);
        feed_req <= 1'b1;
        wait_obs(3, 1'b1);
        check(form_sync, 1'b1);
        repeat (100) @(posedge ref_clk);
        te_cmd <= 1'b0;
        feed_req <= 1'b0;
        wait_obs(3, 1'b0);
        check(form_sync, 1'b0);
        check(original_feed_motor, 1'b1);
        wait_obs(4, 1'b0);
        check({exposure_lamp, original_feed_clutch}, 16'h0000);
        check(pix > 16, 1'b1);
        rd(irf_pkg::REG_IRQ_STAT, d);
        check(d[3:2], 16'h0003);
        results;
    end
endmodule
bind irf_sequencer irf_sequencer_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (.*);
`default_nettype wire
